//--- gate_timer_regs.vh
`ifndef GATE_TIMER_REGS_VH
`define GATE_TIMER_REGS_VH

`define ADDR_TIMER_CONTROL 5'h00
`define ADDR_GATE_CONTROL  5'h04
`define ADDR_COUNT_LOW     5'h08
`define ADDR_COUNT_HIGH    5'h0C
`define ADDR_IRQ_STATUS    5'h10
`define ADDR_IRQ_MASK      5'h14

`define TC_ON_BIT       0
`define TC_WRITE_MASK   8'hFD
`define GC_ENABLE_BIT   7
`define GC_POL_BIT      6
`define GC_TOGGLE_BIT   5
`define GC_SPM_BIT      4
`define GC_GO_BIT       3
`define GC_VAL_BIT      2
`define GC_SRC_HI       1
`define GC_SRC_LO       0

`define SRC_PIN         2'h0
`define SRC_OVERFLOW    2'h1
`define SRC_CMP1        2'h2
`define SRC_CMP2        2'h3

`define IRQ_OVF_BIT     0
`define IRQ_GATE_BIT    1
`define IRQ_WIDTH       2

`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2
`define CTRL_RESET      8'h00
`define COUNT_ALL_ONES  16'hFFFF

`endif

//--- sync2.v
`timescale 1ns/1ps
`default_nettype none
// two-flop synchroniser for pin-level inputs
module sync2 #(
  parameter WIDTH = 1
) (
  // clock and reset
  input  wire             aclk,
  input  wire             aresetn,
  // level in and out
  input  wire [WIDTH-1:0] din,
  output reg  [WIDTH-1:0] dout
);
  reg [WIDTH-1:0] stage;

  always @(posedge aclk) begin
    if (!aresetn) begin
      stage <= {WIDTH{1'b0}};
      dout  <= {WIDTH{1'b0}};
    end else begin
      stage <= din;
      dout  <= stage;
    end
  end
endmodule
`default_nettype wire

//--- gate_path.v
`timescale 1ns/1ps
`default_nettype none
`include "gate_timer_regs.vh"
// gate processing chain and single-pulse acquisition
module gate_path (
  // clock and reset
  input  wire       aclk,
  input  wire       aresetn,
  // configuration
  input  wire       timer_on,
  input  wire       gate_polarity,
  input  wire       gate_toggle_select,
  input  wire       single_pulse_select,
  input  wire [1:0] gate_source_select,
  input  wire       arm_pulse,
  input  wire       clear_pulse,
  // synchronised sources
  input  wire       gate_pin,
  input  wire       overflow_src,
  input  wire       cmp1_src,
  input  wire       cmp2_src,
  // results
  output wire       gate_level,
  output reg        pulse_acquire_flag
);
  reg  selected;
  reg  pol_prev;
  reg  toggle_ff;
  reg  pulse_open;
  reg  tog_prev;
  wire polarized;
  wire toggled;

  always @* begin
    case (gate_source_select)
      `SRC_PIN:      selected = gate_pin;
      `SRC_OVERFLOW: selected = overflow_src;
      `SRC_CMP1:     selected = cmp1_src;
      `SRC_CMP2:     selected = cmp2_src;
      default:       selected = gate_pin;
    endcase
  end

  assign polarized = gate_polarity ? selected : ~selected;
  assign toggled   = gate_toggle_select ? toggle_ff : polarized;

  // toggle flop, cleared when mode off or timer off
  always @(posedge aclk) begin
    if (!aresetn) begin
      toggle_ff <= 1'b0;
      pol_prev  <= 1'b0;
    end else begin
      pol_prev <= polarized;
      if (!gate_toggle_select || !timer_on)
        toggle_ff <= 1'b0;
      else if (polarized && !pol_prev)
        toggle_ff <= ~toggle_ff;
    end
  end

  // acquisition: armed, then open on rise, done on fall
  always @(posedge aclk) begin
    if (!aresetn) begin
      pulse_acquire_flag <= 1'b0;
      pulse_open         <= 1'b0;
      tog_prev           <= 1'b0;
    end else begin
      tog_prev <= toggled;
      if (!single_pulse_select) begin
        pulse_acquire_flag <= 1'b0;
        pulse_open         <= 1'b0;
      end else if (pulse_acquire_flag) begin
        if (toggled && !tog_prev)
          pulse_open <= 1'b1;
        else if (pulse_open && !toggled && tog_prev) begin
          pulse_open         <= 1'b0;
          pulse_acquire_flag <= 1'b0;
        end else if (clear_pulse && !pulse_open)
          pulse_acquire_flag <= 1'b0;
      end else if (arm_pulse) begin
        pulse_acquire_flag <= 1'b1;
        pulse_open         <= 1'b0;
      end
    end
  end

  assign gate_level = single_pulse_select ?
                      (pulse_open & toggled) : toggled;
endmodule
`default_nettype wire

//--- gated_timer.v
`timescale 1ns/1ps
`default_nettype none
`include "gate_timer_regs.vh"
// one gated 16-bit timer with its AXI4-Lite register slave
module gated_timer (
  // clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // write address channel
  input  wire [4:0]  s_axi_awaddr,
  input  wire [2:0]  s_axi_awprot,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  // write data channel
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  // write response channel
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // read address channel
  input  wire [4:0]  s_axi_araddr,
  input  wire [2:0]  s_axi_arprot,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  // read data channel
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // gate sources from outside the clock domain
  input  wire        gate_pin,
  input  wire        overflow_in,
  input  wire        cmp1_out,
  input  wire        cmp2_out,
  // count qualifier from prescaler, same domain
  input  wire        count_tick,
  // status outputs
  output reg  [15:0] count,
  output wire        irq
);
  reg  [7:0]  timer_control;
  reg  [7:0]  gate_control;
  reg  [1:0]  irq_status;
  reg  [1:0]  irq_mask;
  reg  [4:0]  aw_addr;
  reg         aw_held;
  reg  [31:0] w_data;
  reg  [3:0]  w_strb;
  reg         w_held;
  reg         gate_prev;
  wire        timer_on;
  wire        gate_enable;
  wire        gate_level;
  wire        pulse_acquire_flag;
  wire [3:0]  src_sync;
  wire        do_write;
  wire        do_read;
  wire        wr_lane0;
  wire        wr_tc;
  wire        wr_gc;
  wire        wr_lo;
  wire        wr_hi;
  wire        count_en;
  wire        wrap;
  wire        gate_fall;
  wire        rd_status;
  wire [1:0]  events;
  reg  [7:0]  next_low;
  reg  [7:0]  next_high;
  reg  [31:0] next_rdata;
  reg  [1:0]  next_rresp;
  reg  [1:0]  next_bresp;

  sync2 #(.WIDTH(4)) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .din     ({cmp2_out, cmp1_out, overflow_in, gate_pin}),
    .dout    (src_sync)
  );

  assign timer_on    = timer_control[`TC_ON_BIT];
  assign gate_enable = gate_control[`GC_ENABLE_BIT];

  // write channels held until both present
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign do_write      = aw_held && w_held && !s_axi_bvalid;
  assign wr_lane0      = do_write && w_strb[0];
  // full address match, so only mapped words answer OKAY and write
  assign wr_tc = wr_lane0 && (aw_addr == `ADDR_TIMER_CONTROL);
  assign wr_gc = wr_lane0 && (aw_addr == `ADDR_GATE_CONTROL);
  assign wr_lo = wr_lane0 && (aw_addr == `ADDR_COUNT_LOW);
  assign wr_hi = wr_lane0 && (aw_addr == `ADDR_COUNT_HIGH);

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 5'h00;
      w_data  <= 32'h00000000;
      w_strb  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (do_write)
        aw_held <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (do_write)
        w_held <= 1'b0;
    end
  end

  always @* begin
    case (aw_addr)
      `ADDR_TIMER_CONTROL, `ADDR_GATE_CONTROL, `ADDR_COUNT_LOW,
      `ADDR_COUNT_HIGH, `ADDR_IRQ_STATUS, `ADDR_IRQ_MASK:
        next_bresp = `RESP_OKAY;
      default: next_bresp = `RESP_SLVERR;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= next_bresp;
    end else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // control registers
  always @(posedge aclk) begin
    if (!aresetn) begin
      timer_control <= `CTRL_RESET;
      gate_control  <= `CTRL_RESET;
      irq_mask      <= 2'h0;
    end else begin
      if (wr_tc)
        timer_control <= w_data[7:0] & `TC_WRITE_MASK;
      if (wr_gc) begin
        gate_control[`GC_ENABLE_BIT] <= w_data[`GC_ENABLE_BIT];
        gate_control[`GC_POL_BIT]    <= w_data[`GC_POL_BIT];
        gate_control[`GC_TOGGLE_BIT] <= w_data[`GC_TOGGLE_BIT];
        gate_control[`GC_SPM_BIT]    <= w_data[`GC_SPM_BIT];
        gate_control[`GC_SRC_HI:`GC_SRC_LO] <=
          w_data[`GC_SRC_HI:`GC_SRC_LO];
      end
      if (do_write && w_strb[0] && aw_addr == `ADDR_IRQ_MASK)
        irq_mask <= w_data[1:0];
    end
  end

  gate_path u_gate (
    .aclk                (aclk),
    .aresetn             (aresetn),
    .timer_on            (timer_on),
    .gate_polarity       (gate_control[`GC_POL_BIT]),
    .gate_toggle_select  (gate_control[`GC_TOGGLE_BIT]),
    .single_pulse_select (gate_control[`GC_SPM_BIT]),
    .gate_source_select  (gate_control[`GC_SRC_HI:`GC_SRC_LO]),
    .arm_pulse           (wr_gc && w_data[`GC_GO_BIT]),
    .clear_pulse         (wr_gc && !w_data[`GC_GO_BIT]),
    .gate_pin            (src_sync[0]),
    .overflow_src        (src_sync[1]),
    .cmp1_src            (src_sync[2]),
    .cmp2_src            (src_sync[3]),
    .gate_level          (gate_level),
    .pulse_acquire_flag  (pulse_acquire_flag)
  );

  // counter
  assign count_en = timer_on && count_tick &&
                    (!gate_enable || gate_level);
  assign wrap     = count_en && (count == `COUNT_ALL_ONES);

  always @* begin
    next_low  = count[7:0];
    next_high = count[15:8];
    if (count_en)
      {next_high, next_low} = count + 16'h0001;
    if (wr_lo)
      next_low = w_data[7:0];
    if (wr_hi)
      next_high = w_data[7:0];
  end

  always @(posedge aclk) begin
    if (!aresetn)
      count <= 16'h0000;
    else
      count <= {next_high, next_low};
  end

  // events: gate level fall and wrap; read clears
  always @(posedge aclk) begin
    if (!aresetn)
      gate_prev <= 1'b0;
    else
      gate_prev <= gate_level;
  end

  assign gate_fall = gate_prev && !gate_level;
  assign do_read   = s_axi_arvalid && s_axi_arready;
  assign rd_status = do_read && (s_axi_araddr == `ADDR_IRQ_STATUS);
  assign events    = {gate_fall, wrap};

  always @(posedge aclk) begin
    if (!aresetn)
      irq_status <= 2'h0;
    else if (rd_status)
      irq_status <= events;
    else
      irq_status <= irq_status | events;
  end

  assign irq = |(irq_status & irq_mask);

  // read channel
  assign s_axi_arready = !s_axi_rvalid;

  always @* begin
    next_rdata = 32'h00000000;
    next_rresp = `RESP_OKAY;
    case (s_axi_araddr)
      `ADDR_TIMER_CONTROL: next_rdata[7:0] = timer_control;
      `ADDR_GATE_CONTROL: begin
        next_rdata[7:0] = gate_control;
        next_rdata[`GC_GO_BIT]  = pulse_acquire_flag;
        next_rdata[`GC_VAL_BIT] = gate_level;
      end
      `ADDR_COUNT_LOW:  next_rdata[7:0] = count[7:0];
      `ADDR_COUNT_HIGH: next_rdata[7:0] = count[15:8];
      `ADDR_IRQ_STATUS: next_rdata[1:0] = irq_status;
      `ADDR_IRQ_MASK:   next_rdata[1:0] = irq_mask;
      default:          next_rresp = `RESP_SLVERR;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `RESP_OKAY;
    end else if (do_read) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= next_rdata;
      s_axi_rresp  <= next_rresp;
    end else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end
endmodule
`default_nettype wire

//--- gated_timer_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module gated_timer_assertions (
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // bus handshakes
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // counter
  input wire logic        count_tick,
  input wire logic [15:0] count
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // a write lands on the edge that raises bvalid
  a_count_idle_hold: assert property (!count_tick |=>
    $stable(count) || $rose(s_axi_bvalid)) else $error("count moved without tick");
  a_count_step_wrap: assert property ($changed(count) && !$rose(s_axi_bvalid)
    |-> $past(count_tick) && count == $past(count) + 16'h1)
    else $error("count step wrong");
  a_wr_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
  a_rd_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken during response");
  a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write answer late");
endmodule
bind gated_timer gated_timer_assertions chk_i (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .count_tick(count_tick), .count(count));
`default_nettype wire

//--- testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid;
  logic        bready, arvalid, arready, rvalid, rready, count_tick, irq;
  logic [4:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  logic [3:0]  src;
  logic [15:0] count, c;
  int          mismatches = 0, samples_checked = 0, cyc = 0;

  gated_timer dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .gate_pin(src[0]), .overflow_in(src[1]), .cmp1_out(src[2]),
    .cmp2_out(src[3]), .count_tick(count_tick), .count(count), .irq(irq));

  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  task test_done;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      mismatches++;
      test_done();
    end
  end

  task chk(input string n, input [31:0] s, input [31:0] e);
    samples_checked++;
    if (s !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask

  task wr(input [4:0] a, input [7:0] v, input [1:0] r = 2'h0);
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk("bresp", {30'h0, bresp}, {30'h0, r});
  endtask

  task rc(input [4:0] a, input [7:0] e, input [1:0] r = 2'h0);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk($sformatf("reg %h", a), rdata, {24'h0, e});
    chk("rresp", {30'h0, rresp}, {30'h0, r});
  endtask

  // source change plus two-flop synchroniser lag
  task setsrc(input [3:0] v);
    src <= v;
    repeat (4) @(posedge aclk);
  endtask

  task hold_chk(input [15:0] inc);
    repeat (4) @(posedge aclk);
    c = count;
    repeat (4) @(posedge aclk);
    chk("count", {16'h0, count}, {16'h0, c + inc});
  endtask

  initial begin
    aresetn = 1'b0;
    awaddr = 5'h00;
    araddr = 5'h00;
    wdata = 32'h0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    src = 4'h0;
    count_tick = 1'b1;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    // gate status reads 1: low source through active-low polarity
    for (int a = 0; a < 24; a += 4)
      rc(a[4:0], (a == 4) ? 8'h04 : 8'h00);
    wr(5'h18, 8'hAA, 2'h2);
    rc(5'h18, 8'h00, 2'h2);
    wr(5'h00, 8'hFF);
    rc(5'h00, 8'hFD);
    wr(5'h00, 8'h00);
    wr(5'h08, 8'h34);
    wr(5'h0C, 8'h12);
    chk("count", {16'h0, count}, 32'h1234);
    rc(5'h08, 8'h34);
    rc(5'h0C, 8'h12);
    $display("test 1 done");
    wr(5'h08, 8'hFE);
    wr(5'h0C, 8'hFF);
    wr(5'h00, 8'h01);
    repeat (4) @(posedge aclk);
    chk("irq", {31'h0, irq}, 32'h0);
    wr(5'h14, 8'h01);
    chk("irq", {31'h0, irq}, 32'h1);
    rc(5'h10, 8'h01);
    chk("irq", {31'h0, irq}, 32'h0);
    wr(5'h08, 8'h00);
    chk("count low", {24'h0, count[7:0]}, 32'h0);
    hold_chk(16'h4);
    count_tick <= 1'b0;
    hold_chk(16'h0);
    count_tick <= 1'b1;
    $display("test 2 done");
    wr(5'h04, 8'hC0);
    hold_chk(16'h0);
    setsrc(4'h1);
    hold_chk(16'h4);
    wr(5'h04, 8'h80);
    hold_chk(16'h0);
    rc(5'h10, 8'h02);
    for (int s = 0; s < 4; s++) begin
      src <= 4'h1 << s;
      wr(5'h04, 8'h40 | s[7:0]);
      repeat (4) @(posedge aclk);
      rc(5'h04, 8'h44 | s[7:0]);
      setsrc(~(4'h1 << s));
      rc(5'h04, 8'h40 | s[7:0]);
    end
    rc(5'h10, 8'h02);
    $display("test 3 done");
    setsrc(4'h0);
    wr(5'h04, 8'h60);
    setsrc(4'h1);
    rc(5'h04, 8'h64);
    setsrc(4'h0);
    rc(5'h04, 8'h64);
    setsrc(4'h1);
    rc(5'h04, 8'h60);
    setsrc(4'h0);
    setsrc(4'h1);
    wr(5'h00, 8'h00);
    rc(5'h04, 8'h60);
    wr(5'h00, 8'h01);
    wr(5'h04, 8'h40);
    repeat (4) @(posedge aclk);
    rc(5'h04, 8'h44);
    $display("test 4 done");
    setsrc(4'h0);
    wr(5'h04, 8'h50);
    wr(5'h04, 8'h58);
    rc(5'h04, 8'h58);
    setsrc(4'h1);
    rc(5'h04, 8'h5C);
    setsrc(4'h0);
    rc(5'h04, 8'h50);
    setsrc(4'h1);
    rc(5'h04, 8'h50);
    setsrc(4'h0);
    wr(5'h04, 8'h58);
    // acquire bit written 1 so only the mode clear can drop it
    wr(5'h04, 8'h48);
    rc(5'h04, 8'h40);
    $display("test 5 done");
    test_done();
  end
endmodule
`default_nettype wire
